/* plc_frontend_mode_control.sv */
// mode, power and serial-routing control of the powerline front end
// Behaviour
// [R01] A high shutdown request forces every block and the serial port into low power.
// [R02] A low shutdown request lets the blocks and serial port run as configured.
// [R03] Register contents survive shutdown unchanged and remain after release.
// [R04] A high port select steers serial writes into the converter data register.
// [R05] A low port select steers serial reads and writes to the command and data registers.
// [R06] Each switchable block reports settled 10 us after its enable changes.
// [R07] The wire transmitter gates the carrier input with the keying input.
// [R08] A keying input of one leaves the transmitter output undriven.
// [R09] A keying input of zero drives the transmitter output with the carrier level.
// [R10] A converter frame is a left-justified 10-bit word applied when chip select rises.
`timescale 1ns/1ps
module plc_frontend_mode_control
  import mode_control_pkg::*;
#(
  parameter int NBLK = BLOCK_COUNT
) (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire mode_control_pkg::mode_pins_type pins,
  input  wire logic                         cs_n,
  input  wire logic                         sclk,
  input  wire logic                         sdin,
  output logic                              sdout,
  input  wire logic                         carrier_in,
  input  wire logic                         keying_in,
  output logic                              wire_tx_out,
  output logic                              wire_tx_oe,
  output logic [NBLK-1:0]                   block_power,
  output logic [CONV_BITS-1:0]              conv_value,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr
);
  import mode_control_pkg::*;

  // serial, block enable, transmitter and apb state
  serial_state_type         st_r, st_nxt;
  logic [FRAME_BITS-1:0]    sh_r, sh_nxt;
  logic [4:0]               cnt_r, cnt_nxt;
  logic                     sclk_r;
  logic [FRAME_BITS-1:0]    rd_win;
  logic                     sdout_r, sdout_nxt;
  logic [7:0]               regs_r [REG_COUNT];
  logic [7:0]               wr_data;
  logic [ADDR_BITS-1:0]     wr_addr;
  logic                     reg_we;
  logic [CONV_BITS-1:0]     conv_r, conv_nxt;
  logic [NBLK-1:0]          en_cmd_r, en_cmd_nxt;
  logic [NBLK-1:0]          blk_en, blk_settled;
  logic [NBLK-1:0]          power_r, power_nxt;
  logic                     tx_out_r, tx_oe_r;
  logic [31:0]              prdata_r, prdata_nxt;
  logic                     pready_r, pslverr_r, perr_nxt;
  logic                     sd;
  logic                     rise, fall;

  assign sd   = pins.shutdown_request;
  assign rise = sclk && !sclk_r;
  assign fall = !sclk && sclk_r;

  // serial frame engine: r/w, 6-bit address, 8 data bits
  always_comb
  begin
    st_nxt    = st_r;
    sh_nxt    = sh_r;
    cnt_nxt   = cnt_r;
    sdout_nxt = sdout_r;
    conv_nxt  = conv_r;
    reg_we    = 1'b0;
    wr_addr   = sh_r[14:9];
    wr_data   = sh_r[7:0];
    // read address sits just above the bits shifted in after it
    rd_win    = sh_r >> (cnt_r - 5'd7);
    if (sd)
      st_nxt = SP_IDLE; // [R01]
    else
    begin
      unique case (st_r)
        SP_IDLE:
        begin
          cnt_nxt = '0;
          if (!cs_n)
            st_nxt = SP_SHIFT;
        end
        SP_SHIFT:
        begin
          if (rise && cnt_r < 5'(FRAME_BITS))
          begin
            sh_nxt  = {sh_r[FRAME_BITS-2:0], sdin};
            cnt_nxt = cnt_r + 5'd1;
          end
          // read data out on falling edges after the address byte
          if (fall && !pins.port_select && cnt_r >= 5'd8 && cnt_r < 5'(FRAME_BITS))
            sdout_nxt = regs_r[rd_win[ADDR_BITS-1:0]][3'(5'd15 - cnt_r)]; // [R05]
          if (cs_n)
            st_nxt = SP_DONE;
        end
        SP_DONE:
        begin
          st_nxt = SP_IDLE;
          if (cnt_r == 5'(FRAME_BITS))
          begin
            if (pins.port_select)
              conv_nxt = sh_r[FRAME_BITS-1:CONV_LSB_POS]; // [R04] [R10]
            else if (!sh_r[15])
              reg_we = 1'b1; // [R05]
          end
        end
        default: st_nxt = SP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r    <= SP_IDLE;
      sh_r    <= '0;
      cnt_r   <= '0;
      sclk_r  <= 1'b0;
      sdout_r <= 1'b0;
      conv_r  <= CONV_RESET;
      for (int i = 0; i < REG_COUNT; i++)
        regs_r[i] <= REG_RESET;
    end
    else if (!sd) // [R02] data frozen in shutdown, st_r forced to SP_IDLE [R03]
    begin
      st_r    <= st_nxt;
      sh_r    <= sh_nxt;
      cnt_r   <= cnt_nxt;
      sclk_r  <= sclk;
      sdout_r <= sdout_nxt;
      conv_r  <= conv_nxt;
      if (reg_we)
        regs_r[wr_addr] <= wr_data;
    end
    else
      st_r <= st_nxt;
  end

  // block enables: apb command, all off in shutdown
  generate
    for (genvar g = 0; g < NBLK; g++)
    begin : g_blk
      settle_timer #(
        .CYCLES(SETTLE_CYCLES)
      ) u_settle (
        .clk       (clk),
        .arst_n    (arst_n),
        .enable_req(en_cmd_r[g] && !sd), // [R01] [R06]
        .enabled   (blk_en[g]),
        .settled   (blk_settled[g])
      );
    end
  endgenerate

  // apb slave, zero wait states
  always_comb
  begin
    en_cmd_nxt = en_cmd_r;
    prdata_nxt = '0;
    perr_nxt   = 1'b0;
    power_nxt  = blk_en;
    if (psel && !penable)
    begin
      unique case (paddr)
        ADDR_ENABLE_CMD:
        begin
          prdata_nxt = 32'(en_cmd_r);
          if (pwrite)
            en_cmd_nxt = pwdata[NBLK-1:0];
        end
        ADDR_CONV_VALUE:  prdata_nxt = 32'(conv_r);
        ADDR_SETTLE_STAT: prdata_nxt = 32'(blk_settled); // [R06]
        ADDR_SHUTDOWN:    prdata_nxt = {31'h0, sd};
        default:          perr_nxt   = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      en_cmd_r  <= '0;
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      power_r   <= '0;
      tx_out_r  <= 1'b0;
      tx_oe_r   <= 1'b0;
    end
    else
    begin
      en_cmd_r  <= en_cmd_nxt; // [R03] kept through shutdown
      pready_r  <= psel && !penable;
      pslverr_r <= perr_nxt;
      if (psel && !penable)
        prdata_r <= prdata_nxt;
      power_r   <= power_nxt;
      tx_out_r  <= carrier_in && !keying_in; // [R07] [R09]
      tx_oe_r   <= !keying_in && !sd; // [R08] [R01]
    end
  end

  assign sdout       = sdout_r;
  assign conv_value  = conv_r;
  assign block_power = power_r;
  assign wire_tx_out = tx_out_r;
  assign wire_tx_oe  = tx_oe_r;
  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
endmodule : plc_frontend_mode_control

/* mode_control_pkg.sv */
// shared constants and types for the front-end mode controller
package mode_control_pkg;
  localparam int    CLK_HZ           = 50_000_000;
  localparam int    SETTLE_TIME_US   = 10;
  localparam int    SETTLE_CYCLES    = (SETTLE_TIME_US * (CLK_HZ / 1_000_000));
  localparam int    BLOCK_COUNT      = 9;
  localparam int    CONV_BITS        = 10;
  localparam int    CONV_LSB_POS     = 6;
  localparam int    FRAME_BITS       = 16;
  localparam int    ADDR_BITS        = 6;
  localparam int    REG_COUNT        = 64;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [9:0]  CONV_RESET = 10'h000;
  localparam logic [11:0] ADDR_ENABLE_CMD  = 12'h000;
  localparam logic [11:0] ADDR_CONV_VALUE  = 12'h004;
  localparam logic [11:0] ADDR_SETTLE_STAT = 12'h008;
  localparam logic [11:0] ADDR_SHUTDOWN    = 12'h00c;

  typedef enum logic [1:0] {
    SP_IDLE  = 2'b00,
    SP_SHIFT = 2'b01,
    SP_DONE  = 2'b11
  } serial_state_type;

  typedef struct packed {
    logic shutdown_request;
    logic port_select;
  } mode_pins_type;
endpackage : mode_control_pkg

/* settle_timer.sv */
// settling timer for one switchable block
`timescale 1ns/1ps
module settle_timer #(
  parameter int CYCLES = 500
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic enable_req,
  output logic      enabled,
  output logic      settled
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          en_r;
  logic          en_nxt;

  always_comb
  begin
    en_nxt  = enable_req;
    cnt_nxt = cnt_r;
    if (enable_req != en_r)
      cnt_nxt = CW'(CYCLES);
    else if (cnt_r != '0)
      cnt_nxt = cnt_r - 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= '0;
      en_r  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      en_r  <= en_nxt;
    end
  end

  assign enabled = en_r;
  assign settled = (cnt_r == '0) && (en_r == enable_req);
endmodule : settle_timer

/* plc_frontend_mode_control_properties.sv */
// port checker for the mode controller
`timescale 1ns/1ps
module mode_control_checker
  import mode_control_pkg::*;
#(
  parameter int NBLK = BLOCK_COUNT
) (
  input wire logic                         clk,
  input wire logic                         arst_n,
  input wire mode_control_pkg::mode_pins_type pins,
  input wire logic                         cs_n,
  input wire logic                         carrier_in,
  input wire logic                         keying_in,
  input wire logic                         wire_tx_out,
  input wire logic                         wire_tx_oe,
  input wire logic [NBLK-1:0]              block_power,
  input wire logic [CONV_BITS-1:0]         conv_value,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [11:0]                  paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic                         pready,
  input wire logic                         pslverr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  a_keyed_off: assert property (keying_in |=> !wire_tx_oe)
    else $error("keyed transmitter driven");
  a_carrier_follow: assert property (!keying_in && !pins.shutdown_request |=>
    wire_tx_oe && wire_tx_out == $past(carrier_in)) else $error("carrier not followed");
  a_shutdown_off: assert property (pins.shutdown_request [*3] |->
    block_power == '0 && !wire_tx_oe) else $error("block powered in shutdown");
  a_shutdown_hold: assert property (pins.shutdown_request |=> $stable(conv_value))
    else $error("converter changed in shutdown");
  a_conv_path: assert property ($changed(conv_value) |-> $past(pins.port_select))
    else $error("converter written off its path");
  a_conv_on_rise: assert property ($changed(conv_value) |-> $past(cs_n) && $past(cs_n, 2))
    else $error("converter updated inside frame");
  a_enable_write: assert property (setup_s ##0 (pwrite && paddr == ADDR_ENABLE_CMD
    && !pins.shutdown_request) |-> ##3 block_power == $past(pwdata[NBLK-1:0], 3))
    else $error("enable write not applied");
  a_apb_answer: assert property (setup_s |=> answer_s)
    else $error("bus answer late");
  a_bus_error: assert property (pready |-> pslverr == (paddr > ADDR_SHUTDOWN || paddr[1:0] != 2'b00))
    else $error("wrong error response");
endmodule : mode_control_checker
bind plc_frontend_mode_control mode_control_checker #(.NBLK(NBLK)) chk (.clk(clk),
  .arst_n(arst_n), .pins(pins), .cs_n(cs_n), .carrier_in(carrier_in),
  .keying_in(keying_in), .wire_tx_out(wire_tx_out), .wire_tx_oe(wire_tx_oe),
  .block_power(block_power), .conv_value(conv_value), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr));

/* host_serial_model.sv */
// host side of the serial port
`timescale 1ns/1ps
module host_serial_model (
  input  wire logic clk,
  input  wire logic sdout,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdin
);
  logic [7:0] rx_byte = 8'h00;
  initial {cs_n, sclk, sdin} = 3'b100;
  task automatic send(input logic [15:0] word);
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge clk) sdin <= word[i];
      repeat (2) @(posedge clk);
      sclk <= 1'b1;
      // read data bit was launched on the previous falling sclk
      if (i < 8)
        rx_byte <= {rx_byte[6:0], sdout};
      repeat (2) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : send
endmodule : host_serial_model

/* plc_frontend_mode_control_test.sv */
// self-checking bench for the mode controller
`timescale 1ns/1ps
module plc_frontend_mode_control_test;
  import mode_control_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, carrier_in = 1'b0, keying_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic cs_n, sclk, sdin, sdout, wire_tx_out, wire_tx_oe;
  logic [8:0] block_power;
  logic [9:0] conv_value;
  mode_pins_type pins = '0;
  int fails = 0, checks_done = 0;
  always #10 clk = ~clk;
  host_serial_model host (.clk(clk), .sdout(sdout), .cs_n(cs_n), .sclk(sclk), .sdin(sdin));
  plc_frontend_mode_control uut (.clk(clk), .arst_n(arst_n), .pins(pins), .cs_n(cs_n),
    .sclk(sclk), .sdin(sdin), .sdout(sdout), .carrier_in(carrier_in),
    .keying_in(keying_in), .wire_tx_out(wire_tx_out), .wire_tx_oe(wire_tx_oe),
    .block_power(block_power), .conv_value(conv_value), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    check(r, exp);
    check({31'h0, e}, 32'h0);
  endtask : rd
  task automatic t_regs;
    rd(ADDR_ENABLE_CMD, 32'h0);
    rd(ADDR_CONV_VALUE, 32'h0);
    apb(1'b0, 12'h010, '0);
    check({31'h0, e}, 32'h1);
    $display("registers done");
  endtask : t_regs
  task automatic t_power;
    apb(1'b1, ADDR_ENABLE_CMD, 32'h1ff);
    rd(ADDR_SETTLE_STAT, 32'h0);
    check({23'h0, block_power}, 32'h1ff);
    repeat (SETTLE_CYCLES) @(posedge clk);
    rd(ADDR_SETTLE_STAT, 32'h1ff);
    $display("power done");
  endtask : t_power
  task automatic t_conv;
    pins.port_select <= 1'b1;
    host.send(16'hb6c0);
    check({22'h0, conv_value}, 32'h2db);
    rd(ADDR_CONV_VALUE, 32'h2db);
    pins.port_select <= 1'b0;
    host.send(16'h7fc0);
    check({22'h0, conv_value}, 32'h2db);
    $display("converter done");
  endtask : t_conv
  task automatic t_serial;
    host.send(16'h0a5a);
    host.send(16'h8a00);
    check({24'h0, host.rx_byte}, 32'h5a);
    $display("serial done");
  endtask : t_serial
  task automatic t_shutdown;
    apb(1'b1, ADDR_ENABLE_CMD, 32'h0a5);
    pins.shutdown_request <= 1'b1;
    pins.port_select <= 1'b1;
    repeat (3) @(posedge clk);
    check({22'h0, block_power, wire_tx_oe}, 32'h0);
    rd(ADDR_SHUTDOWN, 32'h1);
    host.send(16'hffc0);
    check({22'h0, conv_value}, 32'h2db);
    pins <= '0;
    repeat (3) @(posedge clk);
    check({23'h0, block_power}, 32'h0a5);
    rd(ADDR_ENABLE_CMD, 32'h0a5);
    host.send(16'hfe00);
    check({24'h0, host.rx_byte}, 32'hc0);
    $display("shutdown done");
  endtask : t_shutdown
  task automatic t_wire;
    for (int i = 0; i < 4; i++)
    begin
      carrier_in <= i[0];
      keying_in <= i[1];
      repeat (2) @(posedge clk);
      check({31'h0, wire_tx_oe}, {31'h0, !i[1]});
      if (!i[1]) check({31'h0, wire_tx_out}, {31'h0, i[0]});
    end
    $display("transmitter done");
  endtask : t_wire
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_power();
    t_conv();
    t_serial();
    t_shutdown();
    t_wire();
    print_verdict();
  end
  initial
  begin
    #200000;
    fails++;
    print_verdict();
  end
endmodule : plc_frontend_mode_control_test
